// >>> core/serial_port_defs.svh
/*
 Register offsets, field positions, reset values and timing constants of the serial port core.
 Assumes inclusion by bare name from the package and the core module.
*/
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

`define OFS_RELOAD 8'h00
`define OFS_BUFFER 8'h04
`define OFS_CTRL_ONE 8'h08
`define OFS_CTRL_TWO 8'h0C
`define OFS_CTRL_THREE 8'h10
`define OFS_MASK 8'h14
`define OFS_STATUS 8'h18
`define OFS_EVENT 8'h1C

`define C1_WCOL 7
`define C1_OVF 6
`define C1_EN 5
`define C1_CKP 4
`define C2_ACK_SEQUENCE_ENABLE_BIT 4
`define C2_RECEIVE_ENABLE_BIT 3
`define C2_PEN 2
`define C2_RESTART_ENABLE_BIT 1
`define C2_SEN 0
`define ST_SMP 7
`define ST_CKE 6
`define ST_DA 5
`define ST_STOP 4
`define ST_START 3
`define ST_RW 2
`define ST_UA 1
`define ST_BF 0
`define EV_BCL 0
`define EV_PORT 1

`define MODE_I2C_MASTER 4'h8
`define MODE_SPI_MASTER 4'hA
`define MODE_I2C_10A 4'h7
`define MODE_I2C_10AI 4'hF

`define RESET_BYTE 8'h00
`define EDGES_PER_BYTE 4'hF
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> core/serial_port_pkg.sv
/*
 Types of the serial port core: sequencer states and the packed state record.
 Assumes the constants header is present beside it.
*/
`include "serial_port_defs.svh"

package serial_port_pkg;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b000,
		SEQ_STOP_SDA = 3'b001,
		SEQ_STOP_SCL = 3'b010,
		SEQ_STOP_HOLD = 3'b011,
		SEQ_STOP_REL = 3'b100,
		SEQ_STOP_END = 3'b101,
		SEQ_XFER = 3'b110
	} seq_e;

	typedef struct packed {
		seq_e seq;
		logic [8:0] brgCnt;
		logic [3:0] edgeCnt;
		logic phase;
		logic [7:0] txShift;
		logic [7:0] rxShift;
		logic sclDrvLow;
		logic sdaDrvLow;
		logic [7:0] reload;
		logic [7:0] shiftBuf;
		logic [7:0] ctrlOne;
		logic [7:0] ctrlTwo;
		logic [7:0] ctrlThree;
		logic [7:0] addrMask;
		logic sample_phase_bit;
		logic cke;
		logic dataAddr;
		logic stopSeen;
		logic startSeen;
		logic bufFull;
		logic addrPending;
		logic bclFlag;
		logic portFlag;
		logic sdaPrev;
		logic sclPrev;
		logic awHeld;
		logic [7:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic wLane;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
	} state_s;

endpackage

// >>> core/serial_port_core.sv
/*
 Serial port master core: baud counter, byte engine for two-wire and SPI master modes,
 Stop sequence with collision checks, status flags, AXI4-Lite register slave.
 Assumes pins synchronous to mclk and open-drain wires resolved outside.
*/
// What this block does
// - Stop: SDA low, release SCL, count, sample
// - Stop: SDA low after count is collision
// - Stop: SCL low before SDA high collides
// - Collision sets flag, aborts, releases, idles
// - Stop seen, one baud later flags
// - One baud counter serves both masters
// - Buffer write starts the baud counter
// - Counter stops; clock pin holds level
// - Two reloads per serial clock period
// - SPI: sample-phase bit picks sample point
// - Two-wire: sample-phase bit sets slew control
// - SPI: clock-edge bit picks transmit edge
// - Two-wire: clock-edge bit selects SMBus levels
// - Data-or-address flag marks last byte kind
// - Stop flag: last condition, cleared disabled
// - Start flag: last condition, cleared disabled
// - Two-wire master: direction flag means transmit busy
// - Address-update flag always reads zero
// - Buffer-full on receive or data transmit
`include "serial_port_defs.svh"
module serial_port_core #(
	parameter int ADDR_W = 8
) (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// AXI4-Lite write address and data
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Two-wire open-drain pins
	input wire logic serialDataIn,
	output logic serialDataOut,
	output logic serialDataOe,
	input wire logic serialClockIn,
	output logic serialClockOut,
	output logic serialClockOe,
	// SPI master pins
	output logic spiClock,
	output logic spiDataOut,
	input wire logic spiDataIn,
	// Pad controls and idle indication
	output logic slewLimitEn,
	output logic smbusLevelsEn,
	output logic portIdle
);

	// Only address bits [7:0] are decoded; awaddr[7:0] and araddr[7:0] need a bus of at least eight bits
	if (ADDR_W < 8) begin : g_addrNarrow
		$error("ADDR_W must be at least 8");
	end

	serial_port_pkg::state_s s_r;
	serial_port_pkg::state_s s_nxt;

	logic portOn;
	logic i2cMaster;
	logic spiMaster;
	logic brgExpire;
	logic edgeRise;
	logic edgeFall;
	logic txEdge;
	logic rxEdge;
	logic collide;
	logic [7:0] wAddr;
	logic [7:0] rAddr;
	logic [7:0] statusByte;

	assign portOn = s_r.ctrlOne[`C1_EN];
	assign i2cMaster = portOn && s_r.ctrlOne[3:0] == `MODE_I2C_MASTER;
	assign spiMaster = portOn && s_r.ctrlOne[3:0] == `MODE_SPI_MASTER;
	assign brgExpire = s_r.brgCnt == 9'h000;
	assign edgeRise = brgExpire && !s_r.phase;
	assign edgeFall = brgExpire && s_r.phase;
	assign txEdge = (spiMaster && !s_r.cke) ? edgeRise : edgeFall;
	assign rxEdge = (spiMaster && s_r.sample_phase_bit) ? txEdge : (txEdge ? 1'b0 : brgExpire);
	assign wAddr = s_r.awAddr;
	assign rAddr = araddr[7:0];
	assign statusByte = {s_r.sample_phase_bit, s_r.cke, s_r.dataAddr, s_r.stopSeen, s_r.startSeen,
		s_r.seq == serial_port_pkg::SEQ_XFER && i2cMaster, 1'b0, s_r.bufFull};

	// AXI handshakes; write side takes address and data in either order
	assign awready = !s_r.awHeld && !s_r.bValid;
	assign wready = !s_r.wHeld && !s_r.bValid;
	assign arready = !s_r.rValid;
	assign bvalid = s_r.bValid;
	assign bresp = s_r.bResp;
	assign rvalid = s_r.rValid;
	assign rdata = s_r.rData;
	assign rresp = s_r.rResp;

	// Open drain: output level is always low, enable pulls the wire
	assign serialDataOut = 1'b0;
	assign serialClockOut = 1'b0;
	assign serialDataOe = s_r.sdaDrvLow && portOn;
	assign serialClockOe = s_r.sclDrvLow && portOn;
	assign spiClock = s_r.phase ^ s_r.ctrlOne[`C1_CKP];
	assign spiDataOut = s_r.txShift[7];
	assign slewLimitEn = portOn && !spiMaster && !s_r.sample_phase_bit;
	assign smbusLevelsEn = portOn && !spiMaster && s_r.cke;
	assign portIdle = !(statusByte[`ST_RW] || s_r.ctrlTwo[`C2_SEN] || s_r.ctrlTwo[`C2_RESTART_ENABLE_BIT]
		|| s_r.ctrlTwo[`C2_PEN] || s_r.ctrlTwo[`C2_RECEIVE_ENABLE_BIT] || s_r.ctrlTwo[`C2_ACK_SEQUENCE_ENABLE_BIT]);

	always_comb begin
		s_nxt = s_r;
		collide = 1'b0;

		// Baud counter: loaded with twice the reload plus one, one half clock per run
		if (s_r.seq != serial_port_pkg::SEQ_IDLE && s_r.brgCnt != 9'h000) begin
			s_nxt.brgCnt = s_r.brgCnt - 9'h001;
		end

		// Bus monitor for Start and Stop
		s_nxt.sdaPrev = serialDataIn;
		s_nxt.sclPrev = serialClockIn;
		if (serialClockIn && s_r.sclPrev && s_r.sdaPrev && !serialDataIn) begin
			s_nxt.startSeen = 1'b1;
			s_nxt.stopSeen = 1'b0;
			s_nxt.addrPending = 1'b1;
		end
		if (serialClockIn && s_r.sclPrev && !s_r.sdaPrev && serialDataIn) begin
			s_nxt.stopSeen = 1'b1;
			s_nxt.startSeen = 1'b0;
		end

		unique case (s_r.seq)
			serial_port_pkg::SEQ_IDLE: begin
				if (i2cMaster && s_r.ctrlTwo[`C2_PEN]) begin
					s_nxt.sdaDrvLow = 1'b1;
					s_nxt.seq = serial_port_pkg::SEQ_STOP_SDA;
				end
			end
			serial_port_pkg::SEQ_STOP_SDA: begin
				if (!serialDataIn) begin
					s_nxt.sclDrvLow = 1'b0;
					s_nxt.seq = serial_port_pkg::SEQ_STOP_SCL;
				end
			end
			serial_port_pkg::SEQ_STOP_SCL: begin
				if (serialClockIn) begin
					s_nxt.brgCnt = {s_r.reload, 1'b1};
					s_nxt.seq = serial_port_pkg::SEQ_STOP_HOLD;
				end
			end
			serial_port_pkg::SEQ_STOP_HOLD: begin
				if (!serialClockIn) begin
					collide = 1'b1;
				end else if (brgExpire) begin
					s_nxt.sdaDrvLow = 1'b0;
					s_nxt.brgCnt = {s_r.reload, 1'b1};
					s_nxt.seq = serial_port_pkg::SEQ_STOP_REL;
				end
			end
			serial_port_pkg::SEQ_STOP_REL: begin
				if (!serialClockIn && !serialDataIn) begin
					collide = 1'b1;
				end else if (brgExpire) begin
					if (!serialDataIn) begin
						collide = 1'b1;
					end else begin
						s_nxt.brgCnt = {s_r.reload, 1'b1};
						s_nxt.seq = serial_port_pkg::SEQ_STOP_END;
					end
				end
			end
			serial_port_pkg::SEQ_STOP_END: begin
				if (brgExpire) begin
					s_nxt.ctrlTwo[`C2_PEN] = 1'b0;
					s_nxt.portFlag = 1'b1;
					s_nxt.seq = serial_port_pkg::SEQ_IDLE;
				end
			end
			serial_port_pkg::SEQ_XFER: begin
				if (brgExpire) begin
					s_nxt.brgCnt = {s_r.reload, 1'b1};
					s_nxt.phase = !s_r.phase;
					s_nxt.edgeCnt = s_r.edgeCnt + 4'h1;
					if (i2cMaster) begin
						s_nxt.sclDrvLow = s_r.phase;
					end
				end
				// Arbitration: a released one read back as zero means another master won
				if (i2cMaster && edgeRise && s_r.txShift[7] && !serialDataIn) begin
					collide = 1'b1;
				end
				if (rxEdge) begin
					s_nxt.rxShift = {s_r.rxShift[6:0], spiDataIn};
				end
				if (txEdge && s_r.edgeCnt != `EDGES_PER_BYTE) begin
					s_nxt.txShift = {s_r.txShift[6:0], 1'b0};
					s_nxt.sdaDrvLow = i2cMaster && !s_r.txShift[6];
				end
				if (brgExpire && s_r.edgeCnt == `EDGES_PER_BYTE) begin
					// Counter stops here; the clock pin keeps its last level
					s_nxt.seq = serial_port_pkg::SEQ_IDLE;
					if (spiMaster) begin
						// The last sample, if this edge took one, is already in the shift register
						s_nxt.shiftBuf = s_nxt.rxShift;
						s_nxt.bufFull = 1'b1;
					end else begin
						s_nxt.bufFull = 1'b0;
						s_nxt.sdaDrvLow = 1'b0;
					end
					s_nxt.dataAddr = !s_r.addrPending;
					s_nxt.addrPending = 1'b0;
					s_nxt.portFlag = 1'b1;
				end
			end
			default: begin
				s_nxt.seq = serial_port_pkg::SEQ_IDLE;
			end
		endcase

		if (collide) begin
			s_nxt.bclFlag = 1'b1;
			s_nxt.seq = serial_port_pkg::SEQ_IDLE;
			s_nxt.sdaDrvLow = 1'b0;
			s_nxt.sclDrvLow = 1'b0;
			s_nxt.bufFull = 1'b0;
			s_nxt.ctrlTwo[4:0] = 5'b0_0000;
		end

		// AXI write channel capture
		if (awvalid && awready) begin
			s_nxt.awHeld = 1'b1;
			s_nxt.awAddr = awaddr[7:0];
		end
		if (wvalid && wready) begin
			s_nxt.wHeld = 1'b1;
			s_nxt.wData = wdata;
			s_nxt.wLane = wstrb[0];
		end
		if (s_r.bValid && bready) begin
			s_nxt.bValid = 1'b0;
		end
		if (s_r.awHeld && s_r.wHeld && !s_r.bValid) begin
			s_nxt.awHeld = 1'b0;
			s_nxt.wHeld = 1'b0;
			s_nxt.bValid = 1'b1;
			s_nxt.bResp = `RESP_OKAY;
			unique case (wAddr)
				`OFS_RELOAD: begin
					if (s_r.wLane) begin
						s_nxt.reload = s_r.wData[7:0];
					end
				end
				`OFS_BUFFER: begin
					if (s_r.wLane) begin
						if (s_r.seq != serial_port_pkg::SEQ_IDLE || !portIdle) begin
							// Write while busy is dropped and flagged; the buffer keeps its byte
							s_nxt.ctrlOne[`C1_WCOL] = 1'b1;
						end else begin
							s_nxt.shiftBuf = s_r.wData[7:0];
							if (i2cMaster || spiMaster) begin
								s_nxt.txShift = s_r.wData[7:0];
								s_nxt.brgCnt = {s_r.reload, 1'b1};
								s_nxt.phase = 1'b0;
								s_nxt.edgeCnt = 4'h0;
								s_nxt.seq = serial_port_pkg::SEQ_XFER;
								s_nxt.bufFull = i2cMaster;
								s_nxt.sclDrvLow = i2cMaster;
								s_nxt.sdaDrvLow = i2cMaster && !s_r.wData[7];
							end
						end
					end
				end
				`OFS_CTRL_ONE: begin
					if (s_r.wLane) begin
						s_nxt.ctrlOne[5:0] = s_r.wData[5:0];
						s_nxt.ctrlOne[7:6] = s_r.ctrlOne[7:6] & s_r.wData[7:6];
					end
				end
				`OFS_CTRL_TWO: begin
					if (s_r.wLane) begin
						s_nxt.ctrlTwo[7:5] = s_r.wData[7:5];
						if (portIdle) begin
							s_nxt.ctrlTwo[4:0] = s_r.wData[4:0];
						end
					end
				end
				`OFS_CTRL_THREE: begin
					if (s_r.wLane) begin
						s_nxt.ctrlThree[6:0] = s_r.wData[6:0];
					end
				end
				`OFS_MASK: begin
					if (s_r.wLane) begin
						s_nxt.addrMask = s_r.wData[7:0];
					end
				end
				`OFS_STATUS: begin
					if (s_r.wLane) begin
						s_nxt.sample_phase_bit = s_r.wData[`ST_SMP];
						s_nxt.cke = s_r.wData[`ST_CKE];
					end
				end
				`OFS_EVENT: begin
					// Write one to clear; a flag raised in the same cycle survives
					if (s_r.wLane) begin
						s_nxt.bclFlag = (s_r.bclFlag && !s_r.wData[`EV_BCL]) || collide;
						s_nxt.portFlag = s_nxt.portFlag && (!s_r.wData[`EV_PORT]
							|| (s_r.seq == serial_port_pkg::SEQ_STOP_END && brgExpire)
							|| (s_r.seq == serial_port_pkg::SEQ_XFER && brgExpire
							&& s_r.edgeCnt == `EDGES_PER_BYTE));
					end
				end
				default: begin
					s_nxt.bResp = `RESP_SLVERR;
				end
			endcase
		end

		// AXI read: one cycle after the address is taken
		if (s_r.rValid && rready) begin
			s_nxt.rValid = 1'b0;
		end
		if (arvalid && arready) begin
			s_nxt.rValid = 1'b1;
			s_nxt.rResp = `RESP_OKAY;
			s_nxt.rData = 32'h0000_0000;
			unique case (rAddr)
				`OFS_RELOAD: s_nxt.rData[7:0] = s_r.reload;
				`OFS_BUFFER: begin
					s_nxt.rData[7:0] = s_r.shiftBuf;
					if (s_r.seq == serial_port_pkg::SEQ_IDLE) begin
						s_nxt.bufFull = 1'b0;
					end
				end
				`OFS_CTRL_ONE: s_nxt.rData[7:0] = s_r.ctrlOne;
				`OFS_CTRL_TWO: s_nxt.rData[7:0] = s_r.ctrlTwo;
				`OFS_CTRL_THREE: s_nxt.rData[7:0] = s_r.ctrlThree;
				`OFS_MASK: s_nxt.rData[7:0] = s_r.addrMask;
				`OFS_STATUS: s_nxt.rData[7:0] = statusByte;
				`OFS_EVENT: s_nxt.rData[1:0] = {s_r.portFlag, s_r.bclFlag};
				default: s_nxt.rResp = `RESP_SLVERR;
			endcase
		end

		// Disabled port: stop and start flags drop, pins released, engine idle
		if (!s_nxt.ctrlOne[`C1_EN]) begin
			s_nxt.stopSeen = 1'b0;
			s_nxt.startSeen = 1'b0;
			s_nxt.seq = serial_port_pkg::SEQ_IDLE;
			s_nxt.sdaDrvLow = 1'b0;
			s_nxt.sclDrvLow = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

endmodule // serial_port_core

// >>> verif/i2c_bus_station.sv
/* Wired-AND two-wire bus with pull-ups and other stations.
 Assumes the bench orders each low level the other stations force. */
module i2c_bus_station (
	// Design drivers
	input wire logic sdaOe,
	input wire logic sclOe,
	// Other stations pulling low
	input wire logic holdSdaLow,
	input wire logic holdSclLow,
	// Resolved wires
	output logic sdaLine,
	output logic sclLine
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pull-ups: a released wire goes high at once
	assign sdaLine = !(sdaOe || holdSdaLow);
	assign sclLine = !(sclOe || holdSclLow);
endmodule // i2c_bus_station

// >>> verif/serial_port_core_properties.sv
/* Port-level properties of the serial port core.
 Assumes one clock domain and the constants header on the include path. */
`include "serial_port_defs.svh"
module serial_port_core_properties (
	// Clock, reset
	input wire logic mclk,
	input wire logic rst,
	// Register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	// Pins
	input wire logic serialDataIn,
	input wire logic serialDataOe,
	input wire logic serialClockIn,
	input wire logic serialClockOe,
	input wire logic portIdle
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// Collision release is exempt: idle rises with it
	stopRelease_a: assert property ($fell(serialDataOe) && !serialClockOe && !portIdle |-> serialClockIn)
		else $error("data released while clock low");
	sclLowCol_a: assert property (serialDataOe && !serialClockOe && $fell(serialClockIn)
		|-> ##[0:3] (portIdle && !serialDataOe && !serialClockOe))
		else $error("clock pulled low without abort");
	sdaLowCol_a: assert property ($fell(serialDataOe) && !serialClockOe && !portIdle
		##1 !serialDataIn [*4] |-> ##[0:600] portIdle)
		else $error("data held low without abort");
	idleHold_a: assert property (portIdle && $past(portIdle) |-> $stable(serialClockOe) && $stable(serialDataOe))
		else $error("pins moved while idle");
	awRefuse_a: assert property (awvalid && awready && wvalid && wready |=> !awready && !wready)
		else $error("write accepted twice");
	bAnswer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write response late");
	rAnswer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	rdataUpper_a: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	cover property (serialDataOe && !serialClockOe && $fell(serialClockIn));
	cover property ($rose(bvalid) && bresp == `RESP_SLVERR);
	cover property ($fell(portIdle) ##[1:600] $rose(portIdle));
endmodule // serial_port_core_properties

bind serial_port_core serial_port_core_properties u_serial_port_core_properties (.mclk, .rst, .awvalid, .awready,
	.wvalid, .wready, .bresp, .bvalid, .arvalid, .arready, .rdata, .rvalid, .serialDataIn, .serialDataOe,
	.serialClockIn, .serialClockOe, .portIdle);

// >>> verif/serial_port_brg_stop_arbitration_tb_top.sv
/* Self-checking bench: registers, SPI bytes, Stop with collisions, two-wire byte.
 Assumes the bus station model and the bound checker beside it. */
`include "serial_port_defs.svh"
module serial_port_brg_stop_arbitration_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic holdSda = 1'b0, holdScl = 1'b0, prev;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, v, rl;
	logic [31:0] wdata = 32'h0000_0000, rdata, q;
	logic [3:0] wstrb = 4'h1;
	logic [1:0] bresp, rresp, r;
	logic awready, wready, bvalid, arready, rvalid, sda, scl, sdaOe, sclOe, spiClk, spiOut, slew, smb, idle;
	int nErrors = 0, nTests = 0, n, t, k, last;
	always #50 mclk = ~mclk;
	serial_port_core u_serial_port_core (.mclk(mclk), .rst(rst), .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .serialDataIn(sda), .serialDataOut(), .serialDataOe(sdaOe),
		.serialClockIn(scl), .serialClockOut(), .serialClockOe(sclOe), .spiClock(spiClk), .spiDataOut(spiOut),
		.spiDataIn(spiOut), .slewLimitEn(slew), .smbusLevelsEn(smb), .portIdle(idle));
	i2c_bus_station u_i2c_bus_station (.sdaOe(sdaOe), .sclOe(sclOe), .holdSdaLow(holdSda), .holdSclLow(holdScl),
		.sdaLine(sda), .sclLine(scl));
	function automatic int half(input logic [7:0] reload);
		return 2 * (int'(reload) + 1);
	endfunction
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			nErrors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrapUp();
		$display("tests %0d errors %0d", nTests, nErrors);
		if (nErrors == 0 && nTests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Values seen at the falling edge are those the rising edge samples
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		logic done, awT, wT, arT;
		done = 1'b0;
		@(posedge mclk);
		if (w) begin
			awaddr <= a;
			wdata <= {24'h00_0000, d};
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		for (i = 0; i < 64 && !done; i++) begin
			@(negedge mclk);
			awT = awvalid && awready;
			wT = wvalid && wready;
			arT = arvalid && arready;
			done = w ? bvalid : rvalid;
			q = rdata;
			r = w ? bresp : rresp;
			@(posedge mclk);
			if (awT) awvalid <= 1'b0;
			if (wT) wvalid <= 1'b0;
			if (arT) arvalid <= 1'b0;
		end
		bready <= 1'b0;
		rready <= 1'b0;
		if (!done) begin
			nErrors++;
			wrapUp();
		end
	endtask
	task automatic waitIdle();
		for (t = 0; t < 4000 && !idle; t++) @(negedge mclk);
		if (!idle) begin
			nErrors++;
			wrapUp();
		end
	endtask
	initial begin
		void'($urandom(99373));
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		for (n = 0; n <= 32; n += 4) begin
			bus(1'b0, n[7:0], 8'h00);
			chk("read resp", r, n == 32 ? `RESP_SLVERR : `RESP_OKAY);
			if (n < 32) chk("reset value", q, 0);
		end
		bus(1'b1, 8'h20, 8'hFF);
		chk("unmapped write", r, `RESP_SLVERR);
		for (n = 0; n < 4; n++) begin
			v = 8'($urandom);
			bus(1'b1, `OFS_CTRL_ONE, 8'h28);
			bus(1'b1, `OFS_STATUS, v);
			bus(1'b0, `OFS_STATUS, 8'h00);
			chk("status", q, {24'h00_0000, v & 8'hC0});
			chk("slew", slew, !v[7]);
			chk("smbus", smb, v[6]);
		end
		bus(1'b1, `OFS_MASK, v);
		wstrb <= 4'h0;
		bus(1'b1, `OFS_MASK, ~v);
		wstrb <= 4'h1;
		bus(1'b0, `OFS_MASK, 8'h00);
		chk("masked write", q, {24'h00_0000, v});
		// Loopback is only sure with late shift, so the clock-edge bit stays set
		for (n = 0; n < 3; n++) begin
			rl = 8'h03 + 8'($urandom_range(0, 5));
			v = 8'($urandom);
			bus(1'b1, `OFS_RELOAD, rl);
			bus(1'b1, `OFS_STATUS, {n[1], 7'h40});
			bus(1'b1, `OFS_CTRL_ONE, {3'h1, n[0], 4'hA});
			bus(1'b1, `OFS_BUFFER, v);
			k = 0;
			last = 0;
			prev = spiClk;
			for (t = 1; t < 600; t++) begin
				@(negedge mclk);
				if (spiClk !== prev) begin
					if (k > 0) chk("half period", t - last, half(rl));
					k++;
					last = t;
				end
				prev = spiClk;
			end
			chk("clock edges", k, 16);
			bus(1'b0, `OFS_STATUS, 8'h00);
			chk("spi full", q[0], 1'b1);
			bus(1'b0, `OFS_BUFFER, 8'h00);
			chk("loopback", q, {24'h00_0000, v});
		end
		// Stop: clean, data held low, clock pulled low during the count
		for (n = 0; n < 3; n++) begin
			rl = 8'h03 + 8'($urandom_range(0, 3));
			bus(1'b1, `OFS_EVENT, 8'h03);
			bus(1'b1, `OFS_RELOAD, rl);
			bus(1'b1, `OFS_CTRL_ONE, 8'h28);
			bus(1'b1, `OFS_CTRL_TWO, 8'h04);
			for (t = 0; t < 100 && !sdaOe; t++) @(negedge mclk);
			if (!sdaOe) begin
				nErrors++;
				wrapUp();
			end
			repeat (4) @(posedge mclk);
			holdSda <= (n == 1);
			holdScl <= (n == 2);
			repeat (2) @(posedge mclk);
			holdScl <= 1'b0;
			waitIdle();
			@(posedge mclk);
			holdSda <= 1'b0;
			bus(1'b0, `OFS_EVENT, 8'h00);
			chk("event", q, n == 0 ? 2 : 1);
			bus(1'b0, `OFS_CTRL_TWO, 8'h00);
			chk("enables", q, 0);
			bus(1'b0, `OFS_STATUS, 8'h00);
			// A clock pulled low under a Stop leaves the opening Start as the last condition
			chk("conditions", q[4:3], n == 2 ? 2'b01 : 2'b10);
		end
		bus(1'b1, `OFS_CTRL_ONE, 8'h08);
		bus(1'b0, `OFS_STATUS, 8'h00);
		chk("disabled flags", q & 32'h0000_0018, 0);
		bus(1'b1, `OFS_CTRL_ONE, 8'h28);
		bus(1'b1, `OFS_BUFFER, 8'($urandom));
		bus(1'b0, `OFS_STATUS, 8'h00);
		chk("sending", q & 32'h0000_0005, 32'h0000_0005);
		chk("busy", idle, 1'b0);
		waitIdle();
		bus(1'b0, `OFS_STATUS, 8'h00);
		chk("sent", q[5:0], 6'h00);
		// The byte after a Start is an address, the one after it is data
		bus(1'b1, `OFS_BUFFER, 8'($urandom));
		waitIdle();
		bus(1'b0, `OFS_STATUS, 8'h00);
		chk("data byte", q[5:0], 6'h20);
		wrapUp();
	end
endmodule // serial_port_brg_stop_arbitration_tb_top
